// >>> hrs_harmonic_result_store.sv
// Purpose: formats harmonic engine outputs into software result registers
// Assumes: engine inputs are on mclk; one update pulse per result set
// Notes:   one result slot is written per cycle, 32 cycles per set
// Contract
// - neutral mode updates only harmonic rms and distortion results, no powers
// - neutral rms goes to current rms slots, current sum to voltage slots
// - neutral mode never writes fundamental rms slots; index 1 gives fundamental
// - neutral mode computes distortions only when first index is 1
// - neutral mode with first index 1 loads first distortions with unity
// - harmonic index registers accept values up to 63
// - engine passband 2.8 kHz, 3.3 kHz at -3 dB
// - fundamental active, reactive, apparent powers stored as 24-bit signed
// - nine harmonic power results, three per selected harmonic
// - harmonic powers scaled by one shared signed gain register
// - gain reads as 32 bits, top four zero, sign extended to 28
// - per-harmonic offsets added in active and reactive harmonic paths
// - fundamental and three harmonic power factors stored as 24-bit signed
// - total distortion from total and fundamental rms, 3.21, clamped
// - six harmonic distortions in 3.21 format, clamped at the maximum
// - phase mode writes fundamental rms slots on every update
// - channel field 0..2 selects a phase, 3 selects neutral and sum
// - three 8-bit harmonic index registers written by software
`timescale 1ns/100ps
`default_nettype none
module hrs_harmonic_result_store (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic      [31:0]      hrdata,
  input  wire logic             eng_update,
  input  wire logic [23:0]      fund_v_rms,
  input  wire logic [23:0]      fund_i_rms,
  input  wire logic [23:0]      total_v_rms,
  input  wire logic [23:0]      total_i_rms,
  input  wire logic [2:0][23:0] harm_v_rms,
  input  wire logic [2:0][23:0] harm_i_rms,
  input  wire logic [2:0][23:0] neut_rms,
  input  wire logic [2:0][23:0] phase_current_sum_rms,
  input  wire logic [2:0][23:0] fund_pwr,
  input  wire logic [8:0][23:0] harm_pwr,
  output logic      [1:0]       analyzed_channel_select,
  output logic      [7:0]       first_harmonic_index,
  output logic      [7:0]       second_harmonic_index,
  output logic      [7:0]       third_harmonic_index
);
  typedef struct packed {
    logic [1:0]        chan;
    logic [2:0][7:0]   idx;
    logic [23:0]       gain;
    logic [5:0][23:0]  ofs;      // active x, y, z then reactive x, y, z
    logic              dp_act;
    logic              dp_wr;
    logic              dp_word;
    logic [11:0]       dp_addr;
    hrs_pkg::hrs_seq_t seq;
    logic [4:0]        k;
    logic              nmode;
    logic              hx_fund;
    logic [7:0]        upd_cnt;
    logic [1:0][23:0]  sf;       // fundamental rms v, i
    logic [1:0][23:0]  st;       // total rms v, i
    logic [2:0][23:0]  shv;
    logic [2:0][23:0]  shi;
    logic [2:0][23:0]  sfp;
    logic [8:0][23:0]  shp;      // scaled harmonic powers
  } hrs_state_t;

  hrs_state_t       s_q;
  hrs_state_t       s_d;
  logic [8:0][23:0] hp_scaled;
  logic             job_we;
  logic [23:0]      job_data;
  logic             mem_we;
  logic [4:0]       mem_waddr;
  logic [23:0]      mem_wdata;
  logic [23:0]      mem_rdata;
  logic [31:0]      rd_word;

  function automatic logic [4:0] rel(input logic [4:0] k, input logic [4:0] base);
    return k - base;
  endfunction

  // saturate a 27-bit signed sum into 24 bits
  function automatic logic [23:0] sat24(input logic [26:0] v);
    if (v[26:23] != {4{v[26]}}) begin
      return v[26] ? hrs_pkg::NEG_MAX : hrs_pkg::POS_MAX;
    end
    return v[23:0];
  endfunction

  // bitwise integer square root
  function automatic logic [23:0] isqrt(input logic [47:0] v);
    logic [23:0] root;
    logic [23:0] cand;
    root = '0;
    cand = '0;
    for (int i = 23; i >= 0; i--) begin
      cand = root | (24'h000001 << i);
      if (48'(cand) * 48'(cand) <= v) begin
        root = cand;
      end
    end
    return root;
  endfunction

  // harmonic residual rms, negative inputs count as zero
  function automatic logic [23:0] resid(input logic [23:0] t, input logic [23:0] f);
    logic [47:0] tt;
    logic [47:0] ff;
    tt = t[23] ? 48'h0 : 48'(t) * 48'(t);
    ff = f[23] ? 48'h0 : 48'(f) * 48'(f);
    return (tt > ff) ? isqrt(tt - ff) : 24'h000000;
  endfunction

  // signed ratio, 1.23 for power factor, else 3.21; clamps positive end
  function automatic logic [23:0] ratio(input logic [23:0] num, input logic [23:0] den,
                                        input logic pf);
    logic [23:0] mag;
    logic [47:0] dvd;
    logic [47:0] q;
    logic [23:0] r;
    mag = num[23] ? 24'(-num) : num;
    dvd = {1'b0, mag, 23'h000000} >> (pf ? 0 : hrs_pkg::FRAC_PF - hrs_pkg::FRAC_321);
    q   = '0;
    r   = '0;
    // a zero or negative divisor gives zero rather than a full-scale lie
    if (!den[23] && den != 24'h000000) begin
      q = dvd / {24'h000000, den};
      r = (q > {24'h000000, hrs_pkg::POS_MAX}) ? hrs_pkg::POS_MAX : q[23:0];
    end
    if (pf && num[23]) begin
      r = 24'(-r);
    end
    return r;
  endfunction

  // gain is unity plus gain over 2^23; offsets only on active and reactive
  for (genvar e = 0; e < 9; e++) begin : g_pwr
    logic signed [47:0] prod;
    logic signed [26:0] ofs_e;
    assign prod = $signed(harm_pwr[e]) * $signed(s_q.gain);
    if (e % 3 == 2) begin : g_app
      assign ofs_e = 27'sd0;
    end else begin : g_ofs
      assign ofs_e = 27'($signed(s_q.ofs[(e % 3) * 3 + e / 3]));
    end
    assign hp_scaled[e] = sat24(27'($signed(harm_pwr[e])) + 27'(prod >>> hrs_pkg::GAIN_FRAC)
                                + ofs_e);
  end

  // job decode: what slot k receives in the current mode
  always_comb begin
    logic [23:0] num;
    logic [23:0] den;
    logic        pf;
    logic        use_div;
    num      = '0;
    den      = '0;
    pf       = 1'b0;
    use_div  = 1'b0;
    job_we   = 1'b0;
    job_data = '0;
    if (s_q.k <= hrs_pkg::S_FUND_IRMS) begin
      job_we   = !s_q.nmode;
      job_data = s_q.sf[s_q.k[0]];
    end else if (s_q.k < hrs_pkg::S_HI_RMS) begin
      job_we   = 1'b1;
      job_data = s_q.shv[rel(s_q.k, hrs_pkg::S_HV_RMS)];
    end else if (s_q.k < hrs_pkg::S_FUND_PWR) begin
      job_we   = 1'b1;
      job_data = s_q.shi[rel(s_q.k, hrs_pkg::S_HI_RMS)];
    end else if (s_q.k < hrs_pkg::S_HARM_PWR) begin
      job_we   = !s_q.nmode;
      job_data = s_q.sfp[rel(s_q.k, hrs_pkg::S_FUND_PWR)];
    end else if (s_q.k < hrs_pkg::S_FUND_PF) begin
      job_we   = !s_q.nmode;
      job_data = s_q.shp[rel(s_q.k, hrs_pkg::S_HARM_PWR)];
    end else if (s_q.k == hrs_pkg::S_FUND_PF) begin
      job_we  = !s_q.nmode;
      use_div = 1'b1;
      pf      = 1'b1;
      num     = s_q.sfp[0];
      den     = s_q.sfp[2];
    end else if (s_q.k < hrs_pkg::S_V_THD) begin
      job_we  = !s_q.nmode;
      use_div = 1'b1;
      pf      = 1'b1;
      num     = s_q.shp[3 * rel(s_q.k, hrs_pkg::S_HARM_PF)];
      den     = s_q.shp[3 * rel(s_q.k, hrs_pkg::S_HARM_PF) + 2];
    end else if (s_q.k <= hrs_pkg::S_I_THD) begin
      job_we  = !s_q.nmode;
      use_div = 1'b1;
      num     = resid(s_q.st[s_q.k[0]], s_q.sf[s_q.k[0]]);
      den     = s_q.sf[s_q.k[0]];
    end else if (s_q.k < hrs_pkg::S_HI_DIST) begin
      job_we  = !s_q.nmode || s_q.hx_fund;
      use_div = 1'b1;
      num     = s_q.shv[rel(s_q.k, hrs_pkg::S_HV_DIST)];
      den     = s_q.nmode ? s_q.shv[0] : s_q.sf[0];
    end else begin
      job_we  = !s_q.nmode || s_q.hx_fund;
      use_div = 1'b1;
      num     = s_q.shi[rel(s_q.k, hrs_pkg::S_HI_DIST)];
      den     = s_q.nmode ? s_q.shi[0] : s_q.sf[1];
    end
    if (use_div) begin
      job_data = ratio(num, den, pf);
    end
    // the reference slot is unity by definition, not a rounded ratio
    if (s_q.nmode && (s_q.k == hrs_pkg::S_HV_DIST || s_q.k == hrs_pkg::S_HI_DIST)) begin
      job_data = hrs_pkg::UNITY_321;
    end
  end

  // bus slave, register writes and the update sequencer
  always_comb begin
    s_d = s_q;
    if (hready) begin
      s_d.dp_act  = hsel && htrans[1];
      s_d.dp_wr   = hwrite;
      s_d.dp_word = hsize == hrs_pkg::HSIZE_WORD;
      s_d.dp_addr = {haddr[11:2], 2'b00};
    end
    // result slots are not decoded here, so writes there vanish
    if (s_q.dp_act && s_q.dp_wr && s_q.dp_word) begin
      if (s_q.dp_addr == hrs_pkg::A_CHAN) begin
        s_d.chan = hwdata[1:0];
      end
      if (s_q.dp_addr == hrs_pkg::A_GAIN) begin
        s_d.gain = hwdata[23:0];
      end
      for (int i = 0; i < 3; i++) begin
        // out of range index writes keep the old index
        if (s_q.dp_addr == hrs_pkg::A_IDX + 12'(4 * i) && hwdata[7:0] <= hrs_pkg::IDX_MAX) begin
          s_d.idx[i] = hwdata[7:0];
        end
        if (s_q.dp_addr == hrs_pkg::A_ACT_OFS + 12'(4 * i)) begin
          s_d.ofs[i] = hwdata[23:0];
        end
        if (s_q.dp_addr == hrs_pkg::A_REA_OFS + 12'(4 * i)) begin
          s_d.ofs[3 + i] = hwdata[23:0];
        end
      end
    end
    // an update during a run is dropped; the set in flight stays whole
    case (s_q.seq)
      hrs_pkg::ST_IDLE: begin
        if (eng_update) begin
          s_d.seq     = hrs_pkg::ST_RUN;
          s_d.k       = '0;
          s_d.nmode   = s_q.chan == hrs_pkg::CHAN_NEUTRAL;
          s_d.hx_fund = s_q.idx[0] == hrs_pkg::IDX_FUND;
          s_d.sf      = {fund_i_rms, fund_v_rms};
          s_d.st      = {total_i_rms, total_v_rms};
          s_d.shv     = s_d.nmode ? phase_current_sum_rms : harm_v_rms;
          s_d.shi     = s_d.nmode ? neut_rms : harm_i_rms;
          s_d.sfp     = fund_pwr;
          s_d.shp     = hp_scaled;
        end
      end
      hrs_pkg::ST_RUN: begin
        s_d.k = s_q.k + 5'h01;
        if (s_q.k == hrs_pkg::S_LAST) begin
          s_d.seq     = hrs_pkg::ST_IDLE;
          s_d.upd_cnt = s_q.upd_cnt + 8'h01;
        end
      end
      default: begin
        s_d.seq = hrs_pkg::ST_IDLE;
      end
    endcase
  end

  // one state register; snapshots clear so first results are defined
  always_ff @(posedge mclk) begin
    if (reset) begin
      s_q      <= '0;
      s_q.chan <= hrs_pkg::CHAN_RST;
      s_q.idx  <= {3{hrs_pkg::IDX_RST}};
      s_q.gain <= hrs_pkg::GAIN_RST;
      s_q.ofs  <= {6{hrs_pkg::OFS_RST}};
      s_q.seq  <= hrs_pkg::ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // only the sequencer writes results
  assign mem_we    = s_q.seq == hrs_pkg::ST_RUN && job_we;
  assign mem_waddr = s_q.k;
  assign mem_wdata = job_data;

  hrs_result_mem #(
    .DW (hrs_pkg::DW),
    .AW (hrs_pkg::RES_AW)
  ) u_mem (
    .mclk  (mclk),
    .reset (reset),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .raddr (haddr[6:2]),
    .rdata (mem_rdata)
  );

  // read mux in the data phase, so a write just before is seen
  always_comb begin
    rd_word = '0;
    if (s_q.dp_addr <= hrs_pkg::A_RES_END) begin
      rd_word = {8'h00, mem_rdata};
    end else if (s_q.dp_addr == hrs_pkg::A_CHAN) begin
      rd_word = {30'h0, s_q.chan};
    end else if (s_q.dp_addr == hrs_pkg::A_GAIN) begin
      rd_word = {4'h0, {4{s_q.gain[23]}}, s_q.gain};
    end else if (s_q.dp_addr == hrs_pkg::A_STATUS) begin
      rd_word = {16'h0, s_q.upd_cnt, 6'h0, s_q.nmode, s_q.seq == hrs_pkg::ST_RUN};
    end
    for (int i = 0; i < 3; i++) begin
      if (s_q.dp_addr == hrs_pkg::A_IDX + 12'(4 * i)) begin
        rd_word = {24'h0, s_q.idx[i]};
      end
      if (s_q.dp_addr == hrs_pkg::A_ACT_OFS + 12'(4 * i)) begin
        rd_word = {8'h00, s_q.ofs[i]};
      end
      if (s_q.dp_addr == hrs_pkg::A_REA_OFS + 12'(4 * i)) begin
        rd_word = {8'h00, s_q.ofs[3 + i]};
      end
    end
  end

  // zero wait states, always OKAY; indices above 63 sit past the band
  assign hrdata                  = (s_q.dp_act && !s_q.dp_wr) ? rd_word : 32'h0;
  assign hreadyout               = 1'b1;
  assign hresp                   = 1'b0;
  assign analyzed_channel_select = s_q.chan;
  assign first_harmonic_index    = s_q.idx[0];
  assign second_harmonic_index   = s_q.idx[1];
  assign third_harmonic_index    = s_q.idx[2];

  // checks
  logic [7:0] wr_byte;
  logic       idx_wr;
  assign wr_byte = hwdata[7:0];
  assign idx_wr  = s_q.dp_act && s_q.dp_wr && s_q.dp_word && s_q.dp_addr == hrs_pkg::A_IDX;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_phase_start;
    s_q.seq == hrs_pkg::ST_IDLE && eng_update && s_q.chan != hrs_pkg::CHAN_NEUTRAL;
  endsequence
  sequence s_neut_start;
    s_q.seq == hrs_pkg::ST_IDLE && eng_update && s_q.chan == hrs_pkg::CHAN_NEUTRAL;
  endsequence

  property p_fund_rms_phase;
    s_phase_start |=> mem_we && mem_waddr == hrs_pkg::S_FUND_VRMS
                      && mem_wdata == $past(fund_v_rms);
  endproperty
  a_fund_rms_phase: assert property (p_fund_rms_phase)
    else $error("fundamental rms not written after phase update");

  property p_neut_rms_slot;
    s_neut_start |-> ##6 (mem_we && mem_waddr == hrs_pkg::S_HI_RMS
                          && mem_wdata == $past(neut_rms[0], 6));
  endproperty
  a_neut_rms_slot: assert property (p_neut_rms_slot)
    else $error("neutral rms not placed in current rms slot");

  property p_neut_no_fund;
    s_q.nmode && mem_we |-> mem_waddr > hrs_pkg::S_FUND_IRMS;
  endproperty
  a_neut_no_fund: assert property (p_neut_no_fund)
    else $error("fundamental rms written in neutral mode");

  property p_neut_rms_only;
    s_q.nmode && mem_we |-> mem_waddr < hrs_pkg::S_FUND_PWR || mem_waddr >= hrs_pkg::S_HV_DIST;
  endproperty
  a_neut_rms_only: assert property (p_neut_rms_only)
    else $error("power or total result written in neutral mode");

  property p_neut_no_dist;
    s_q.nmode && !s_q.hx_fund |-> !(mem_we && mem_waddr >= hrs_pkg::S_HV_DIST);
  endproperty
  a_neut_no_dist: assert property (p_neut_no_dist)
    else $error("distortion written without fundamental reference");

  property p_unity;
    s_q.nmode && s_q.hx_fund && mem_we && mem_waddr == hrs_pkg::S_HI_DIST
      |-> mem_wdata == hrs_pkg::UNITY_321;
  endproperty
  a_unity: assert property (p_unity)
    else $error("first distortion slot is not unity");

  property p_idx_take;
    idx_wr && wr_byte <= hrs_pkg::IDX_MAX |=> first_harmonic_index == $past(wr_byte);
  endproperty
  a_idx_take: assert property (p_idx_take)
    else $error("legal index write not taken");

  property p_idx_keep;
    idx_wr && wr_byte > hrs_pkg::IDX_MAX |=> $stable(first_harmonic_index);
  endproperty
  a_idx_keep: assert property (p_idx_keep)
    else $error("index above maximum was taken");

  property p_gain_read;
    s_q.dp_act && !s_q.dp_wr && s_q.dp_addr == hrs_pkg::A_GAIN
      |-> hrdata[31:28] == 4'h0 && hrdata[27:24] == {4{hrdata[23]}};
  endproperty
  a_gain_read: assert property (p_gain_read)
    else $error("gain read not sign extended to 28 bits");

  property p_dist_clamp;
    mem_we && mem_waddr >= hrs_pkg::S_V_THD |-> !mem_wdata[23];
  endproperty
  a_dist_clamp: assert property (p_dist_clamp)
    else $error("distortion above clamp value");

  property p_unity_gain;
    s_q.seq == hrs_pkg::ST_IDLE && eng_update && s_q.gain == 24'h0 && s_q.ofs == '0
      |=> s_q.shp == $past(harm_pwr);
  endproperty
  a_unity_gain: assert property (p_unity_gain)
    else $error("zero gain changed harmonic power");

  property p_ro_results;
    mem_we |-> s_q.seq == hrs_pkg::ST_RUN;
  endproperty
  a_ro_results: assert property (p_ro_results)
    else $error("result written outside an update run");
endmodule
`default_nettype wire

// >>> hrs_pkg.sv
// Purpose: shared constants and types of the harmonic result store
// Assumes: 32-bit AHB-Lite slave, single word transfers
// Notes:   a result slot number is also its result memory address
`default_nettype none
package hrs_pkg;
  localparam int unsigned DW     = 24;
  localparam int unsigned RES_AW = 5;
  // result slots, byte address is slot times four
  localparam logic [4:0] S_FUND_VRMS = 5'h00;
  localparam logic [4:0] S_FUND_IRMS = 5'h01;
  localparam logic [4:0] S_HV_RMS    = 5'h02; // three slots
  localparam logic [4:0] S_HI_RMS    = 5'h05; // three slots
  localparam logic [4:0] S_FUND_PWR  = 5'h08; // active, reactive, apparent
  localparam logic [4:0] S_HARM_PWR  = 5'h0B; // nine slots, three per harmonic
  localparam logic [4:0] S_FUND_PF   = 5'h14;
  localparam logic [4:0] S_HARM_PF   = 5'h15; // three slots
  localparam logic [4:0] S_V_THD     = 5'h18;
  localparam logic [4:0] S_I_THD     = 5'h19;
  localparam logic [4:0] S_HV_DIST   = 5'h1A; // three slots
  localparam logic [4:0] S_HI_DIST   = 5'h1D; // three slots
  localparam logic [4:0] S_LAST      = 5'h1F;
  // control register byte addresses
  localparam logic [11:0] A_RES_END = 12'h07C;
  localparam logic [11:0] A_CHAN    = 12'h080;
  localparam logic [11:0] A_IDX     = 12'h084; // three words
  localparam logic [11:0] A_GAIN    = 12'h090;
  localparam logic [11:0] A_ACT_OFS = 12'h094; // three words
  localparam logic [11:0] A_REA_OFS = 12'h0A0; // three words
  localparam logic [11:0] A_STATUS  = 12'h0AC;
  localparam logic [2:0]  HSIZE_WORD = 3'h2;
  // reset values
  localparam logic [1:0]  CHAN_RST = 2'h0;
  localparam logic [7:0]  IDX_RST  = 8'h00;
  localparam logic [23:0] GAIN_RST = 24'h000000;
  localparam logic [23:0] OFS_RST  = 24'h000000;
  // codes and formats
  localparam logic [1:0]  CHAN_NEUTRAL = 2'h3;
  localparam logic [7:0]  IDX_MAX      = 8'h3F;
  localparam logic [7:0]  IDX_FUND     = 8'h01;
  localparam logic [23:0] UNITY_321    = 24'h1FFFFF;
  localparam logic [23:0] POS_MAX      = 24'h7FFFFF;
  localparam logic [23:0] NEG_MAX      = 24'h800000;
  localparam int unsigned FRAC_321     = 21;
  localparam int unsigned FRAC_PF      = 23;
  localparam int unsigned GAIN_FRAC    = 23;
  // engine band limits in hertz, kept for reference
  localparam int unsigned PASSBAND_HZ  = 2800;
  localparam int unsigned BW_3DB_HZ    = 3300;
  typedef enum logic {ST_IDLE, ST_RUN} hrs_seq_t;
endpackage
`default_nettype wire

// >>> hrs_result_mem.sv
// Purpose: result memory, one write port and one registered read port
// Assumes: write and read on the same clock
// Notes:   a read of a slot written in the same cycle returns old data
`timescale 1ns/100ps
`default_nettype none
module hrs_result_mem #(
  parameter int unsigned DW = 24,
  parameter int unsigned AW = 5
) (
  input  wire logic          mclk,
  input  wire logic          reset,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  typedef struct packed {
    logic [(1<<AW)-1:0][DW-1:0] mem;
    logic [DW-1:0]              rd;
  } hrs_mem_st_t;

  hrs_mem_st_t s_q;
  hrs_mem_st_t s_d;

  // read before write, so a bus read sees a whole old value
  always_comb begin
    s_d    = s_q;
    s_d.rd = s_q.mem[raddr];
    if (we) begin
      s_d.mem[waddr] = wdata;
    end
  end

  // results read as zero until the first update
  always_ff @(posedge mclk) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rd;
endmodule
`default_nettype wire

// >>> hrs_testbench.sv
// Purpose: self-checking bench for the harmonic result store
// Assumes: zero wait state slave, hready looped back from hreadyout
// Notes:   selected results of each set are read back over the bus and compared
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic             mclk = 1'b0;
  logic             reset = 1'b1;
  logic             hsel = 1'b0;
  logic [31:0]      haddr = 32'h0;
  logic [1:0]       htrans = 2'h0;
  logic             hwrite = 1'b0;
  logic [2:0]       hsize = 3'h2;
  logic [31:0]      hwdata = 32'h0;
  logic             hreadyout;
  logic             hresp;
  logic [31:0]      hrdata;
  logic             upd = 1'b0;
  logic [23:0]      fv = 24'h0, fi = 24'h0, tv = 24'h0, ti = 24'h0;
  logic [2:0][23:0] hv = '0, hi = '0, nr = '0, sr = '0, fp = '0, ao, ro;
  logic [8:0][23:0] hpw = '0;
  logic [1:0]       ch;
  logic [7:0]       ix0, ix1, ix2;
  logic [23:0]      keep;
  logic [31:0]      rdw;
  int               fail_count = 0;
  int               checked = 0;
  int               cyc = 0;

  hrs_harmonic_result_store u_dut (.mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .eng_update(upd),
    .fund_v_rms(fv), .fund_i_rms(fi), .total_v_rms(tv), .total_i_rms(ti), .harm_v_rms(hv),
    .harm_i_rms(hi), .neut_rms(nr), .phase_current_sum_rms(sr), .fund_pwr(fp), .harm_pwr(hpw),
    .analyzed_channel_select(ch), .first_harmonic_index(ix0),
    .second_harmonic_index(ix1), .third_harmonic_index(ix2));

  // free running clock, 10 ns period
  always #5 mclk = ~mclk;

  // hang guard, far above the few hundred cycles the tests need
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one single word transfer; read data taken at the edge ending the data phase
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= hrs_pkg::HSIZE_WORD;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rchk(input string nm, input logic [11:0] a, input logic [23:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(nm, {8'h00, e}, x);
  endtask

  function automatic logic [11:0] sa(input int s);
    return 12'(s * 4);
  endfunction

  // expected harmonic power: raw plus raw times gain, plus offset, saturated
  function automatic logic [23:0] hpx(input logic [23:0] r, g, o);
    logic signed [47:0] rr, p, s;
    rr = $signed({{24{r[23]}}, r});
    p = rr * $signed({{24{g[23]}}, g});
    s = rr + (p >>> 23) + $signed({{24{o[23]}}, o});
    if (s > 48'sh7FFFFF) return 24'h7FFFFF;
    if (s < -48'sh800000) return 24'h800000;
    return s[23:0];
  endfunction

  // expected 3.21 ratio, clamped at the largest positive code
  function automatic logic [23:0] dv(input logic [23:0] n, d);
    logic [47:0] q;
    if ($signed(d) <= 0) return 24'h0;
    q = ({24'h0, n} << 21) / {24'h0, d};
    return (q > 48'h7FFFFF) ? 24'h7FFFFF : q[23:0];
  endfunction

  function automatic logic [23:0] rs();
    logic [19:0] x;
    x = 20'($urandom);
    return {{4{x[19]}}, x};
  endfunction

  // one result set, then wait out the 32 slot writes
  task automatic run;
    @(posedge mclk);
    upd <= 1'b1;
    @(posedge mclk);
    upd <= 1'b0;
    repeat (40) @(posedge mclk);
  endtask

  initial begin
    void'($urandom(86));
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    rchk("chan", hrs_pkg::A_CHAN, 24'h0);
    for (int i = 0; i < 3; i++) rchk("idx", hrs_pkg::A_IDX + sa(i), 24'h0);
    rchk("gain", hrs_pkg::A_GAIN, 24'h0);
    rchk("fund_act", sa(8), 24'h0);
    // reset gain and offsets leave harmonic powers unscaled
    for (int k = 0; k < 9; k++) hpw[k] <= rs();
    run();
    rchk("raw_pwr", sa(11), hpw[0]);
    $display("test reset done");
    for (int c = 3; c >= 0; c--) begin
      wr(hrs_pkg::A_CHAN, 32'(c));
      // register output shows the write one edge after the data phase
      @(posedge mclk);
      chk("chan_out", 32'(c), {30'h0, ch});
    end
    wr(hrs_pkg::A_IDX, 32'h3F);
    wr(hrs_pkg::A_IDX, 32'h40);
    rchk("idx_max", hrs_pkg::A_IDX, 24'h3F);
    chk("idx_out", 32'h3F, {24'h0, ix0});
    wr(hrs_pkg::A_IDX + 12'h4, 32'h2);
    wr(hrs_pkg::A_IDX + 12'h8, 32'h3);
    @(posedge mclk);
    chk("idx_y", 32'h2, {24'h0, ix1});
    chk("idx_z", 32'h3, {24'h0, ix2});
    wr(hrs_pkg::A_GAIN, 32'h00C00000);
    // gain reads back sign extended to 28 bits, top nibble zero
    bus(1'b0, hrs_pkg::A_GAIN, 32'h0, rdw);
    chk("gain_sx", 32'h0FC00000, rdw);
    chk("gain_top", 32'h0, {rdw[31:28], 28'h0});
    wr(sa(8), 32'h123456);
    rchk("ro_slot", sa(8), 24'h0);
    rchk("unmapped", 12'hFF0, 24'h0);
    for (int i = 0; i < 3; i++) begin
      ao[i] = rs();
      ro[i] = rs();
      wr(hrs_pkg::A_ACT_OFS + sa(i), {8'h0, ao[i]});
      wr(hrs_pkg::A_REA_OFS + sa(i), {8'h0, ro[i]});
    end
    $display("test registers done");
    // phase set: small fundamental voltage forces a clamped distortion
    fv <= 24'h000100;
    tv <= 24'h000100;
    fi <= 24'($urandom_range(256, 65535));
    ti <= 24'h0;
    hv <= {rs(), 24'($urandom_range(1, 511)), 24'h010000};
    hi <= {rs(), rs(), rs()};
    fp <= {24'h200000, rs(), 24'h100000};
    for (int k = 0; k < 9; k++) hpw[k] <= rs();
    run();
    rchk("fund_v", sa(0), fv);
    rchk("fund_i", sa(1), fi);
    rchk("harm_v", sa(2), hv[0]);
    for (int k = 0; k < 3; k++) rchk("fund_pwr", sa(8 + k), fp[k]);
    for (int k = 0; k < 9; k++) rchk("harm_pwr", sa(11 + k), hpx(hpw[k], 24'hC00000,
      (k % 3 == 0) ? ao[k / 3] : (k % 3 == 1) ? ro[k / 3] : 24'h0));
    rchk("fund_pf", sa(20), 24'h400000);
    rchk("v_thd", sa(24), 24'h0);
    rchk("hd_clamp", sa(26), 24'h7FFFFF);
    rchk("hd_y", sa(27), dv(hv[1], 24'h000100));
    $display("test phase done");
    // neutral set with fundamental selected in the first slot
    wr(hrs_pkg::A_CHAN, 32'h3);
    wr(hrs_pkg::A_IDX, 32'h1);
    fv <= ~fv;
    for (int k = 0; k < 3; k++) begin
      nr[k] <= 24'($urandom_range(4096, 1048575));
      sr[k] <= 24'($urandom_range(4096, 1048575));
    end
    fp[0] <= rs();
    run();
    rchk("n_fund_v", sa(0), 24'h000100);
    rchk("n_pwr", sa(8), 24'h100000);
    for (int k = 0; k < 3; k++) rchk("n_sum", sa(2 + k), sr[k]);
    for (int k = 0; k < 3; k++) rchk("n_neut", sa(5 + k), nr[k]);
    rchk("unity_v", sa(26), hrs_pkg::UNITY_321);
    rchk("unity_i", sa(29), hrs_pkg::UNITY_321);
    rchk("hd_sum", sa(27), dv(sr[1], sr[0]));
    rchk("hd_neut", sa(31), dv(nr[2], nr[0]));
    keep = dv(sr[2], sr[0]);
    // neutral without the fundamental index: distortions stay put
    wr(hrs_pkg::A_IDX, 32'h5);
    sr[2] <= sr[2] + 24'h1000;
    run();
    rchk("n_sum_z", sa(4), sr[2]);
    rchk("hd_keep", sa(28), keep);
    $display("test neutral done");
    give_verdict();
  end
endmodule
`default_nettype wire
